/* File: verilog/cds_consts.vh */
`ifndef CDS_CONSTS_VH
`define CDS_CONSTS_VH

// Register map
`define CDS_ADDR_ENTRY    32'h0000_0000
`define CDS_ADDR_CTRL     32'h0000_0004
`define CDS_ADDR_STATUS   32'h0000_0008
`define CDS_ADDR_SETTLE   32'h0000_000c

// Entry fields
`define CDS_ENTRY_W       8
`define CDS_DIODE_A_BIT   0
`define CDS_DIODE_B_BIT   1
`define CDS_DUR_LSB       2
`define CDS_DUR_W         6

// Control register fields
`define CDS_CTRL_PREP_BIT 0
`define CDS_CTRL_TICK_BIT 1

// Settling register fields
`define CDS_SET_ON_LSB    0
`define CDS_SET_OFF_LSB   16

// Reset values
`define CDS_SETTLE_RST    16'h0010
`define CDS_DIODE_RST     1'b0

// Queue depth (power of two)
`define CDS_DEPTH         8
`define CDS_AW            3
`define CDS_SW            16

`endif

/* File: verilog/cds_scheduler.v */
`timescale 1ns/1ns
// Summary of operation
// - Host-written 8-bit entries queue in a FIFO, preserving write order.
// - Popped entry: two low bits drive diodes, upper six bits give integrations.
// - Whenever the queue has room, request a refill interrupt.
// - Scan prepare empties the queue and requests the first entry.
// - Each write strobe pushes one entry; pushes blocked while full.
// - Request level holds until a write, drops one cycle, reasserts if room.
// - Each rise of the request level yields one single-cycle interrupt pulse.
// - Pop reloads duration counter from top bits; switchers latch their bit.
// - Integration start decrements counter; at 1 or zero, pop instead.
// - Freshly loaded count is not decremented at its loading integration.
// - Empty queue at pop: nothing read or reloaded; retry later.
// - First prepare cycle gives a one-cycle clear of queue, request, counter.
// - Prepare clear leaves switcher states and settling counts untouched.
// - Switchers see next target early; stable and state latch together.
// - Each integration start refreshes stability from the settling countdown.
// - Load strobe reaches switchers only when an entry was popped.
// - Candidate settle time: turn-on, turn-off, or residual if unchanged.
// - Settling counter loads on load strobe, counts down, stops at zero.
// - Refresh sets stable when residual count is zero, else clears it.
// - During load the stability uses the candidate; otherwise the residual.
// - Schedule register write pulses the push strobe with its contents.
// - Integration start is every cycle the sequencer pin is high, or a single-cycle tick from the control register tick bit.
`include "cds_consts.vh"

module cds_scheduler
(
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Timing
  input  wire        integ_tick,
  input  wire        scan_prepare,
  // Diode control and header flags
  output wire [1:0]  diode_on,
  output wire [1:0]  diode_stable,
  // Interrupt request pulse to gateway
  output reg         refill_irq
);

  // Bus address phase capture
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [3:0]  addr_q;
  reg [31:0] rdata_q;
  reg [`CDS_SW-1:0] on_time_q;
  reg [`CDS_SW-1:0] off_time_q;
  reg        sw_prep_q;
  reg        sw_tick_q;

  wire addr_ok = hsel & hready & htrans[1];

  function [31:0] reg_addr;
    input [3:0] a;
    begin
      reg_addr = {28'h000_0000, a};
    end
  endfunction

  // Queue storage
  reg [`CDS_ENTRY_W-1:0] fifo_q [0:`CDS_DEPTH-1];
  reg [`CDS_AW:0]        wptr_q;
  reg [`CDS_AW:0]        rptr_q;
  wire fifo_empty = (wptr_q == rptr_q);
  wire fifo_full  = (wptr_q[`CDS_AW] != rptr_q[`CDS_AW]) &&
                    (wptr_q[`CDS_AW-1:0] == rptr_q[`CDS_AW-1:0]);
  wire [`CDS_ENTRY_W-1:0] head = fifo_q[rptr_q[`CDS_AW-1:0]];

  // Schedule write strobe
  wire wr_entry = wr_pend_q && (reg_addr(addr_q) == `CDS_ADDR_ENTRY);
  wire push     = wr_entry & ~fifo_full;

  // Prepare and tick merge of pin and software sources
  wire prep_in  = scan_prepare | sw_prep_q;
  wire tick     = integ_tick | sw_tick_q;
  reg  prep_q;
  wire clr      = prep_in & ~prep_q;

  // Duration counter and pop
  reg  [`CDS_DUR_W-1:0] dur_q;
  wire due  = tick && (dur_q <= 6'h01);
  wire pop  = due & ~fifo_empty;

  // Request level and pulse
  reg req_q;
  reg req_seen_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
      addr_q     <= 4'h0;
      rdata_q    <= 32'h0000_0000;
      on_time_q  <= `CDS_SETTLE_RST;
      off_time_q <= `CDS_SETTLE_RST;
      sw_prep_q  <= 1'b0;
      sw_tick_q  <= 1'b0;
    end
    else
    begin
      // Only the low sixteen bytes are mapped; write aliases above are ignored, reads decode only haddr[3:0]
      wr_pend_q <= addr_ok & hwrite & (haddr[31:4] == 28'h000_0000);
      rd_pend_q <= addr_ok & ~hwrite;
      sw_tick_q <= 1'b0;
      if (addr_ok)
        addr_q <= haddr[3:0];
      if (wr_pend_q)
      begin
        case (reg_addr(addr_q))
          `CDS_ADDR_CTRL:
          begin
            sw_prep_q <= hwdata[`CDS_CTRL_PREP_BIT];
            sw_tick_q <= hwdata[`CDS_CTRL_TICK_BIT];
          end
          `CDS_ADDR_SETTLE:
          begin
            on_time_q  <= hwdata[`CDS_SET_ON_LSB +: `CDS_SW];
            off_time_q <= hwdata[`CDS_SET_OFF_LSB +: `CDS_SW];
          end
          default:
            sw_prep_q <= sw_prep_q;
        endcase
      end
      if (addr_ok & ~hwrite)
      begin
        case ({28'h000_0000, haddr[3:0]})
          `CDS_ADDR_CTRL:
            rdata_q <= {30'h0000_0000, sw_tick_q, sw_prep_q};
          `CDS_ADDR_STATUS:
            rdata_q <= {18'h0_0000, dur_q, diode_stable, diode_on,
                        req_q, fifo_full, fifo_empty, 1'b0};
          `CDS_ADDR_SETTLE:
            rdata_q <= {off_time_q, on_time_q};
          default:
            rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Queue, counter and request logic, cleared by prepare pulse
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wptr_q     <= {(`CDS_AW+1){1'b0}};
      rptr_q     <= {(`CDS_AW+1){1'b0}};
      dur_q      <= 6'h00;
      prep_q     <= 1'b0;
      req_q      <= 1'b0;
      req_seen_q <= 1'b0;
      refill_irq <= 1'b0;
    end
    else
    begin
      prep_q <= prep_in;
      if (clr)
      begin
        wptr_q     <= {(`CDS_AW+1){1'b0}};
        rptr_q     <= {(`CDS_AW+1){1'b0}};
        dur_q      <= 6'h00;
        req_q      <= 1'b0;
        req_seen_q <= 1'b0;
        refill_irq <= 1'b0;
      end
      else
      begin
        if (push)
          wptr_q <= wptr_q + 1'b1;
        if (pop)
        begin
          rptr_q <= rptr_q + 1'b1;
          dur_q  <= head[`CDS_DUR_LSB +: `CDS_DUR_W];
        end
        else if (tick && !due)
          dur_q <= dur_q - 6'h01;
        // Level drops for one cycle after a write, else follows room
        if (wr_entry)
          req_q <= 1'b0;
        else
          req_q <= ~fifo_full;
        req_seen_q <= req_q;
        refill_irq <= req_q & ~req_seen_q;
      end
    end
  end

  always @(posedge hclk)
  begin
    if (push)
      fifo_q[wptr_q[`CDS_AW-1:0]] <= hwdata[`CDS_ENTRY_W-1:0];
  end

  // Two diode switchers, untouched by prepare clear
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_sw
      reg [`CDS_SW-1:0] settle_q;
      reg               on_q;
      reg               stable_q;
      wire              nxt = head[g];
      reg [`CDS_SW-1:0] cand;
      always @*
      begin
        if (!on_q && nxt)
          cand = on_time_q;
        else if (on_q && !nxt)
          cand = off_time_q;
        else
          cand = settle_q;
      end
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          settle_q <= {`CDS_SW{1'b0}};
          on_q     <= `CDS_DIODE_RST;
          stable_q <= 1'b0;
        end
        else
        begin
          if (pop)
          begin
            on_q     <= nxt;
            settle_q <= cand;
          end
          else if (settle_q != {`CDS_SW{1'b0}})
            settle_q <= settle_q - 1'b1;
          if (tick)
            stable_q <= pop ? (cand == {`CDS_SW{1'b0}}) :
                              (settle_q == {`CDS_SW{1'b0}});
        end
      end
      assign diode_on[g]     = on_q;
      assign diode_stable[g] = stable_q;
    end
  endgenerate

endmodule // cds_scheduler

/* File: verification/cds_sva.sv */
`timescale 1ns/1ns
module cds_sva
(
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Timing and outputs
  input wire        integ_tick,
  input wire        scan_prepare,
  input wire [1:0]  diode_on,
  input wire [1:0]  diode_stable,
  input wire        refill_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
  a_irq_single: assert property (refill_irq |=> !refill_irq)
    else $error("irq pulse too long");
  a_diode_tick: assert property ($changed(diode_on) |-> $past(integ_tick))
    else $error("diode moved without tick");
  a_flag_tick: assert property ($changed(diode_stable) |-> $past(integ_tick))
    else $error("flag moved without tick");
  // Settle times stay at their nonzero reset value in every run
  a_change_unstable: assert property ($past(integ_tick) |-> ((diode_on ^ $past(diode_on)) & diode_stable) == 2'b00)
    else $error("stable set on a changing diode");
  a_prep_keep: assert property (scan_prepare && !integ_tick |=> $stable(diode_on))
    else $error("diode moved in prepare");
  a_clear_irq: assert property ($rose(scan_prepare) |-> ##[1:5] refill_irq)
    else $error("no irq after prepare");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
endmodule // cds_sva

bind cds_scheduler cds_sva u_sva (.*);

/* File: verification/cds_host.sv */
`timescale 1ns/1ns
module cds_host
(
  // Clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output logic             hsel = 1'b0,
  output logic [31:0]      haddr = 32'h0,
  output logic [1:0]       htrans = 2'h0,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'h2,
  output logic [31:0]      hwdata = 32'h0
);
  // Single word transfer; entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule // cds_host

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        hclk = 0, hresetn = 0, integ_tick = 0, scan_prepare = 0;
  wire         hsel, hwrite, hreadyout, hresp, refill_irq;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans, diode_on, diode_stable;
  wire  [2:0]  hsize;
  int          num_errors = 0, checks_done = 0, irqs = 0;
  logic [31:0] x = 38, q;
  logic [7:0]  e;
  logic [7:0]  ent [$];
  logic [1:0]  old;
  always #10 hclk = ~hclk;
  always @(posedge hclk) irqs += refill_irq;
  cds_scheduler u_dut (.*, .hready(hreadyout));
  cds_host u_host (.*, .hready(hreadyout));

  function logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function int span(logic [7:0] v);
    return v[7:2] == 6'h0 ? 1 : int'(v[7:2]);
  endfunction
  task chk(string n, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (ex !== got)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, ex, got);
    end
  endtask
  // Host writes only when asked
  task wrq(logic [7:0] v);
    while (irqs == 0) @(posedge hclk);
    irqs--;
    u_host.xfer(1'b1, 32'h0, {24'h0, v}, q);
    ent.push_back(v);
  endtask
  task tick();
    integ_tick <= 1'b1;
    @(posedge hclk);
    integ_tick <= 1'b0;
    repeat (20) @(posedge hclk);
  endtask
  task summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    u_host.xfer(1'b0, 32'h10, 32'h0, q);
    chk("unmapped", 32'h0, q);
    u_host.xfer(1'b0, 32'h8, 32'h0, q);
    chk("empty", 32'h1, {31'h0, q[1]});
    repeat (8) wrq(8'(rnd() & 32'h0f));
    repeat (12) @(posedge hclk);
    chk("irq when full", 32'h0, 32'(irqs));
    u_host.xfer(1'b0, 32'h8, 32'h0, q);
    chk("full", 32'h1, {31'h0, q[2]});
    u_host.xfer(1'b1, 32'h0, 32'h07, q);
    old = 2'h0;
    while (ent.size() > 0)
    begin
      e = ent.pop_front();
      repeat (span(e))
      begin
        tick();
        chk("diode_on", {30'h0, e[1:0]}, {30'h0, diode_on});
        chk("stable", {30'h0, ~(e[1:0] ^ old)}, {30'h0, diode_stable});
        old = e[1:0];
      end
    end
    repeat (2) tick();
    chk("held", {30'h0, old}, {30'h0, diode_on});
    wrq(8'h0d);
    scan_prepare <= 1'b1;
    repeat (3) @(posedge hclk);
    scan_prepare <= 1'b0;
    u_host.xfer(1'b0, 32'h8, 32'h0, q);
    chk("cleared", 32'h1, {31'h0, q[1]});
    tick();
    chk("kept", {30'h0, old}, {30'h0, diode_on});
    summarize();
  end
  initial
  begin
    #300000;
    num_errors++;
    summarize();
  end
endmodule // tb_top
